//--- logic/uofg_pkg.sv
package uofg_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_FADDR      = 12'h000;
   localparam logic [11:0] OFS_INDEX      = 12'h00e;
   localparam logic [11:0] OFS_IDX_BASE   = 12'h410;
   localparam logic [11:0] OFS_IDX_LAST   = 12'h41f;
   localparam logic [11:0] OFS_FLAT_BASE  = 12'h500;
   localparam logic [11:0] OFS_FLAT_LAST  = 12'h54f;
   localparam logic [11:0] OFS_PHY_CTRL   = 12'h600;
   localparam logic [11:0] OFS_ROLE_STAT  = 12'h604;
   localparam logic [11:0] OFS_RX_DMA_EN  = 12'h608;
   localparam logic [11:0] OFS_QHEAD_BASE = 12'h620;
   localparam logic [11:0] OFS_BUFCNT_BASE = 12'h640;
   localparam logic [11:0] OFS_SESSION    = 12'h660;
   localparam logic [11:0] OFS_FIFO_PORT  = 12'h680;

   // Slot word offsets inside one endpoint 16-byte slot
   localparam logic [3:0] SLOT_RXCSR     = 4'h0;
   localparam logic [3:0] SLOT_TXFIFOSZ  = 4'h4;
   localparam logic [3:0] SLOT_RXFIFOSZ  = 4'h8;
   localparam logic [3:0] SLOT_FIFOADDR  = 4'hc;

   // Endpoint and FIFO geometry
   localparam int NUM_EP        = 5;
   localparam int FIFO_BYTES    = 4096;
   localparam int FIFO_AW       = 12;
   localparam int EP0_FIFO_SIZE = 64;
   localparam logic [FIFO_AW-1:0] EP0_FIFO_START = 12'h000;
   localparam int RX_DMA_REQ_BIT = 5;

   // PHY control fields
   localparam int PHY_CLKSRC_LSB  = 0;
   localparam int PHY_POL_BIT     = 4;
   localparam int PHY_SESEND_BIT  = 5;
   localparam int PHY_VBDET_BIT   = 6;
   localparam int PHY_PLLON_BIT   = 7;
   localparam int PHY_PDWN_BIT    = 8;
   localparam int PHY_OTG_POWER_DOWN_BIT = 9;
   localparam int PHY_OSCPDWN_BIT = 10;
   localparam int PHY_CLKGD_BIT   = 11;
   localparam logic [31:0] PHY_CTRL_RESET = 32'h0000_0700;

   // Descriptor control word fields
   localparam int DESC_SOP_BIT   = 31;
   localparam int DESC_EOP_BIT   = 30;
   localparam int DESC_OWN_BIT   = 29;
   localparam int DESC_EOQ_BIT   = 28;
   localparam int DESC_ZLP_BIT   = 23;
   localparam int DESC_ABORT_BIT = 19;

   // PLL lock time
   localparam int PLL_LOCK_NS    = 1000;
   localparam int CLK_PERIOD_NS  = 4;
   localparam int PLL_LOCK_CYC   = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      UOFG_PHY_OFF  = 2'b00,
      UOFG_PHY_LOCK = 2'b01,
      UOFG_PHY_GOOD = 2'b11
   } uofg_phy_e;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } uofg_bus_s;

   typedef struct packed {
      logic [FIFO_AW-1:0] start;
      logic [3:0]         size_code;
      logic               dbl;
   } uofg_fifo_cfg_s;

endpackage

//--- logic/uofg_fifo_region.sv
`timescale 1ns/1ps
module uofg_fifo_region
   import uofg_pkg::*;
#(
   parameter int EP_NUM = 1
) (
   // Configuration
   input  wire uofg_pkg::uofg_fifo_cfg_s cfg,
   // Access
   input  wire logic [FIFO_AW-1:0]        offset,
   output logic [FIFO_AW-1:0]             ram_addr,
   output logic                           ok
);
   // Region: 8 << size, doubled if double-buffered
   wire [13:0] region_bytes = (EP_NUM == 0) ? 14'(EP0_FIFO_SIZE)
                              : 14'((14'h8 << cfg.size_code) << cfg.dbl);
   wire [FIFO_AW-1:0] base = (EP_NUM == 0) ? EP0_FIFO_START : cfg.start;
   wire [13:0] end_excl = 14'(base) + region_bytes;

   // Out-of-RAM regions are refused whole, never wrapped
   assign ok       = (end_excl <= 14'(FIFO_BYTES)) && (14'(offset) < region_bytes);
   assign ram_addr = FIFO_AW'(14'(base) + 14'(offset));
endmodule

//--- logic/uofg_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Indexed 16-byte window shows the endpoint chosen by the index register.
// - Flat map gives each endpoint its own 16-byte slot, endpoint 0 first.
// - Supply enable goes high by itself when host role and session active.
// - Peripheral role keeps supply enable low, charge pump off.
// - One shared 4K FIFO RAM, split among endpoints by software.
// - Per endpoint FIFO start, packet size, double-buffer held in indexed registers.
// - Only endpoints 1 to 4 placed freely; endpoint 0 fixed 64 bytes at 0.
// - PHY stays powered down after reset until software clears power-down bits 8 and 10 and sets PLL-on bit 7.
// - Polarity bit 0 keeps data lines normal, 1 swaps them.
// - Clock good status bit sets once the PHY PLL locks.
// - Identify pin high means peripheral, low means host.
// - VBUS pin level is taken as VBUS present.
// - Writing a buffer count adds to the free-buffer count.
// - Descriptor is four words: next, buffer, size, control with ownership.
// - Control word bits: 31 SOP, 30 EOP, 29 owner, 28 END_OF_QUEUE_FLAG, 23 ZLP, 19 abort.
// - Bus reset in peripheral role clears index, address, FIFO pointer and status.
module uofg_core
   import uofg_pkg::*;
#(
   parameter int NUM_RX_CH    = 4,
   parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Pins from the cable side
   input  wire logic        role_identify_pin,
   input  wire logic        vbus_pin,
   input  wire logic        phy_pll_locked,
   input  wire logic        usb_bus_reset,
   // Link data from the transceiver
   input  wire logic        line_rx_p,
   input  wire logic        line_rx_n,
   // PHY controls and outputs
   output logic             vbus_supply_enable_out,
   output logic             data_plus_pin,
   output logic             data_minus_pin,
   output logic [31:0]      phy_control_reg,
   output logic             host_role,
   output logic             rx_dma_start,
   output logic             reset_event
);
   import uofg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] id_sync_reg, vbus_sync_reg, lock_sync_reg, brst_sync_reg, rxp_sync_reg, rxn_sync_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         id_sync_reg   <= 2'h3;
         vbus_sync_reg <= 2'h0;
         lock_sync_reg <= 2'h0;
         brst_sync_reg <= 2'h0;
         rxp_sync_reg  <= 2'h0;
         rxn_sync_reg  <= 2'h0;
      end else begin
         id_sync_reg   <= {id_sync_reg[0], role_identify_pin};
         vbus_sync_reg <= {vbus_sync_reg[0], vbus_pin};
         lock_sync_reg <= {lock_sync_reg[0], phy_pll_locked};
         brst_sync_reg <= {brst_sync_reg[0], usb_bus_reset};
         rxp_sync_reg  <= {rxp_sync_reg[0], line_rx_p};
         rxn_sync_reg  <= {rxn_sync_reg[0], line_rx_n};
      end
   end

   wire id_high      = id_sync_reg[1];
   wire vbus_present = vbus_sync_reg[1];
   wire is_host      = !id_high;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   uofg_bus_s bus;
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   wire        hit_idx    = (bus.addr >= OFS_IDX_BASE) && (bus.addr <= OFS_IDX_LAST);
   wire        hit_flat   = (bus.addr >= OFS_FLAT_BASE) && (bus.addr <= OFS_FLAT_LAST);
   wire [3:0]  flat_ep    = bus.addr[7:4];
   logic [3:0] index_reg;
   // Both windows resolve to one endpoint slot
   wire [3:0]  sel_ep     = hit_idx ? index_reg : flat_ep;
   wire [3:0]  sel_word   = {bus.addr[3:2], 2'b00};
   wire        hit_ep     = (hit_idx || hit_flat) && (sel_ep < 4'(NUM_EP));
   wire        hit_qhead  = (bus.addr[11:4] == OFS_QHEAD_BASE[11:4]);
   wire        hit_bufcnt = (bus.addr[11:4] == OFS_BUFCNT_BASE[11:4]);
   wire [1:0]  ch_sel     = bus.addr[3:2];
   wire        ch_ok      = 3'(ch_sel) < 3'(NUM_RX_CH);

   ////////////////////////////////////////////////////////////////////////////
   // Endpoint state
   logic [7:0]       faddr_reg;
   logic [15:0]      rxcsr_reg [NUM_EP];
   uofg_fifo_cfg_s   txcfg_reg [NUM_EP];
   uofg_fifo_cfg_s   rxcfg_reg [NUM_EP];
   logic [10:0]      txmaxp_reg [NUM_EP];
   logic [10:0]      rxmaxp_reg [NUM_EP];
   logic             bus_reset_clr;

   // Bus reset counts only in peripheral role
   logic brst_d_reg;
   assign bus_reset_clr = brst_sync_reg[1] && !brst_d_reg && !is_host;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         index_reg  <= 4'h0;
         faddr_reg  <= 8'h00;
         brst_d_reg <= 1'b0;
      end else begin
         brst_d_reg <= brst_sync_reg[1];
         if (bus_reset_clr) begin
            index_reg <= 4'h0;
            faddr_reg <= 8'h00;
         end else if (bus.wr && bus.addr == OFS_INDEX) begin
            index_reg <= bus.wdata[3:0];
         end else if (bus.wr && bus.addr == OFS_FADDR) begin
            faddr_reg <= {1'b0, bus.wdata[6:0]};
         end
      end
   end

   generate
      for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
         wire we = bus.wr && hit_ep && (sel_ep == 4'(e));
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               rxcsr_reg[e]  <= 16'h0000;
               txcfg_reg[e]  <= '0;
               rxcfg_reg[e]  <= '0;
               txmaxp_reg[e] <= 11'h000;
               rxmaxp_reg[e] <= 11'h000;
            end else if (bus_reset_clr) begin
               rxcsr_reg[e] <= 16'h0000;
            end else if (we) begin
               // Endpoint 0 sizing is fixed and read-only
               case (sel_word)
                  SLOT_RXCSR:    rxcsr_reg[e] <= bus.wdata[15:0];
                  SLOT_TXFIFOSZ: if (e != 0) begin
                     txcfg_reg[e].size_code <= bus.wdata[3:0];
                     txcfg_reg[e].dbl       <= bus.wdata[4];
                     txmaxp_reg[e]          <= bus.wdata[26:16];
                  end
                  SLOT_RXFIFOSZ: if (e != 0) begin
                     rxcfg_reg[e].size_code <= bus.wdata[3:0];
                     rxcfg_reg[e].dbl       <= bus.wdata[4];
                     rxmaxp_reg[e]          <= bus.wdata[26:16];
                  end
                  SLOT_FIFOADDR: if (e != 0) begin
                     txcfg_reg[e].start <= bus.wdata[FIFO_AW-1:0];
                     rxcfg_reg[e].start <= bus.wdata[16+FIFO_AW-1:16];
                  end
                  default: ;
               endcase
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Shared FIFO RAM behind a byte port
   logic [7:0]         fifo_ram [FIFO_BYTES];
   logic [FIFO_AW-1:0] fifo_ptr_reg;
   logic [FIFO_AW-1:0] region_addr;
   logic               region_ok;
   wire  [2:0]         cur_ep = (index_reg < 4'(NUM_EP)) ? index_reg[2:0] : 3'h0;

   uofg_fifo_region #(
      .EP_NUM (1)
   ) u_region (
      .cfg      (cur_ep == 3'h0 ? uofg_fifo_cfg_s'{start: EP0_FIFO_START, size_code: 4'h3, dbl: 1'b0}
                                : rxcfg_reg[cur_ep]),
      .offset   (fifo_ptr_reg),
      .ram_addr (region_addr),
      .ok       (region_ok)
   );

   wire fifo_hit = bus.addr == OFS_FIFO_PORT;
   wire fifo_acc = fifo_hit && (bus.wr || bus.rd) && region_ok;
   logic [7:0] fifo_q_reg;

   always_ff @(posedge clk_sys) begin
      if (fifo_hit && bus.wr && region_ok) begin
         fifo_ram[region_addr] <= bus.wdata[7:0];
      end
      fifo_q_reg <= fifo_ram[region_addr];
   end

   // Pointer restarts on index change or bus reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fifo_ptr_reg <= '0;
      end else if (bus_reset_clr || (bus.wr && bus.addr == OFS_INDEX)) begin
         fifo_ptr_reg <= '0;
      end else if (fifo_acc) begin
         fifo_ptr_reg <= fifo_ptr_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PHY control and PLL lock
   logic [31:0] phy_ctrl_reg;
   uofg_phy_e   phy_state_reg;
   logic [15:0] lock_cnt_reg;
   wire phy_powered = !phy_ctrl_reg[PHY_PDWN_BIT] && !phy_ctrl_reg[PHY_OSCPDWN_BIT] && phy_ctrl_reg[PHY_PLLON_BIT];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phy_ctrl_reg <= PHY_CTRL_RESET;
      end else if (bus.wr && bus.addr == OFS_PHY_CTRL) begin
         phy_ctrl_reg <= {20'h0, 1'b0, bus.wdata[10:0]};
      end
   end

   // Lock needs PLL indication and a settle count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phy_state_reg <= UOFG_PHY_OFF;
         lock_cnt_reg  <= 16'h0000;
      end else begin
         case (phy_state_reg)
            UOFG_PHY_OFF: begin
               lock_cnt_reg <= 16'h0000;
               if (phy_powered) begin
                  phy_state_reg <= UOFG_PHY_LOCK;
               end
            end
            UOFG_PHY_LOCK: begin
               if (!phy_powered) begin
                  phy_state_reg <= UOFG_PHY_OFF;
               end else if (lock_sync_reg[1] && lock_cnt_reg >= 16'(PLL_LOCK_CYCLES - 1)) begin
                  phy_state_reg <= UOFG_PHY_GOOD;
               end else if (lock_cnt_reg < 16'(PLL_LOCK_CYCLES - 1)) begin
                  lock_cnt_reg <= lock_cnt_reg + 16'h0001;
               end
            end
            UOFG_PHY_GOOD: begin
               if (!phy_powered || !lock_sync_reg[1]) begin
                  phy_state_reg <= UOFG_PHY_OFF;
               end
            end
            default: phy_state_reg <= UOFG_PHY_OFF;
         endcase
      end
   end

   wire clk_good = (phy_state_reg == UOFG_PHY_GOOD);

   ////////////////////////////////////////////////////////////////////////////
   // Session and VBUS supply
   logic session_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         session_reg <= 1'b0;
      end else if (bus.wr && bus.addr == OFS_SESSION) begin
         session_reg <= bus.wdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive DMA set-up
   logic                rx_dma_en_reg;
   logic [31:0]         qhead_reg [NUM_RX_CH];
   logic [15:0]         bufcnt_reg [NUM_RX_CH];

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_dma_en_reg <= 1'b0;
      end else if (bus.wr && bus.addr == OFS_RX_DMA_EN) begin
         rx_dma_en_reg <= bus.wdata[0];
      end
   end

   generate
      for (genvar c = 0; c < NUM_RX_CH; c++) begin : g_ch
         wire ch_hit = ch_ok && (ch_sel == 2'(c));
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               qhead_reg[c]  <= 32'h0000_0000;
               bufcnt_reg[c] <= 16'h0000;
            end else begin
               // Descriptors are 16-byte aligned
               if (bus.wr && hit_qhead && ch_hit) begin
                  qhead_reg[c] <= {bus.wdata[31:4], 4'h0};
               end
               if (bus.wr && hit_bufcnt && ch_hit) begin
                  bufcnt_reg[c] <= bufcnt_reg[c] + bus.wdata[15:0];
               end
            end
         end
      end
   endgenerate

   // Start needs DMA, queue head and request set
   wire [2:0] bc_ep     = 3'(ch_sel) + 3'h1;
   wire start_now = bus.wr && hit_bufcnt && ch_ok && rx_dma_en_reg && (qhead_reg[ch_sel] != 32'h0)
                    && rxcsr_reg[bc_ep][RX_DMA_REQ_BIT] && (bus.wdata[15:0] != 16'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [31:0] ep_rdata;
   always_comb begin
      ep_rdata = 32'h0;
      case (sel_word)
         SLOT_RXCSR:    ep_rdata = {16'h0, rxcsr_reg[sel_ep[2:0]]};
         SLOT_TXFIFOSZ: ep_rdata = {5'h0, txmaxp_reg[sel_ep[2:0]], 11'h0,
                                   txcfg_reg[sel_ep[2:0]].dbl, txcfg_reg[sel_ep[2:0]].size_code};
         SLOT_RXFIFOSZ: ep_rdata = {5'h0, rxmaxp_reg[sel_ep[2:0]], 11'h0,
                                   rxcfg_reg[sel_ep[2:0]].dbl, rxcfg_reg[sel_ep[2:0]].size_code};
         SLOT_FIFOADDR: ep_rdata = {4'h0, rxcfg_reg[sel_ep[2:0]].start, 4'h0, txcfg_reg[sel_ep[2:0]].start};
         default:       ep_rdata = 32'h0;
      endcase
   end

   wire [31:0] phy_rd = {phy_ctrl_reg[31:12], clk_good, phy_ctrl_reg[10:0]};
   logic [31:0] rd_next;
   always_comb begin
      if (hit_ep)                          rd_next = ep_rdata;
      else if (bus.addr == OFS_INDEX)      rd_next = {28'h0, index_reg};
      else if (bus.addr == OFS_FADDR)      rd_next = {24'h0, faddr_reg};
      else if (bus.addr == OFS_PHY_CTRL)   rd_next = phy_rd;
      else if (bus.addr == OFS_ROLE_STAT)  rd_next = {29'h0, session_reg, vbus_present, is_host};
      else if (bus.addr == OFS_RX_DMA_EN)  rd_next = {31'h0, rx_dma_en_reg};
      else if (bus.addr == OFS_SESSION)    rd_next = {31'h0, session_reg};
      else if (hit_qhead && ch_ok)         rd_next = qhead_reg[ch_sel];
      else if (hit_bufcnt && ch_ok)        rd_next = {16'h0, bufcnt_reg[ch_sel]};
      else                                 rd_next = 32'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   logic fifo_rd_reg;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata              <= 32'h0;
         fifo_rd_reg            <= 1'b0;
         vbus_supply_enable_out <= 1'b0;
         data_plus_pin          <= 1'b0;
         data_minus_pin         <= 1'b0;
         phy_control_reg        <= PHY_CTRL_RESET;
         host_role              <= 1'b0;
         rx_dma_start           <= 1'b0;
         reset_event            <= 1'b0;
      end else begin
         fifo_rd_reg            <= bus.rd && fifo_hit && region_ok;
         reg_rdata              <= bus.rd ? rd_next : 32'h0;
         vbus_supply_enable_out <= is_host && session_reg;
         // Polarity 1 exchanges the two data lines
         data_plus_pin          <= phy_ctrl_reg[PHY_POL_BIT] ? rxn_sync_reg[1] : rxp_sync_reg[1];
         data_minus_pin         <= phy_ctrl_reg[PHY_POL_BIT] ? rxp_sync_reg[1] : rxn_sync_reg[1];
         phy_control_reg        <= phy_rd;
         host_role              <= is_host;
         rx_dma_start           <= start_now;
         reset_event            <= bus_reset_clr;
      end
   end

   // FIFO reads land a cycle later
   wire unused_fifo_q = fifo_rd_reg & (|fifo_q_reg);
endmodule

//--- tb/uofg_properties.sv
`timescale 1ns/1ps
module uofg_properties
   import uofg_pkg::*;
#(
   parameter int NUM_RX_CH       = 4,
   parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rstn,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Cable side
   input wire logic        role_identify_pin,
   input wire logic        phy_pll_locked,
   input wire logic        line_rx_p,
   input wire logic        line_rx_n,
   // Outputs
   input wire logic        vbus_supply_enable_out,
   input wire logic        data_plus_pin,
   input wire logic        data_minus_pin,
   input wire logic [31:0] phy_control_reg,
   input wire logic        host_role,
   input wire logic        rx_dma_start,
   input wire logic        reset_event
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Level checks wait out the synchronisers
   logic [2:0] up_cnt;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
   end
   //////////////////////////////////////////////////////////////////////
   a_supply_off_periph: assert property (!host_role && $past(!host_role) |-> !vbus_supply_enable_out)
      else $error("supply on as peripheral");
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not idle zero");
   a_phy_read_copy: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PHY_CTRL
      |-> reg_rdata == $past(phy_control_reg))
      else $error("phy read differs");
   a_pdwn_no_clkgood: assert property ($past(phy_control_reg[PHY_PDWN_BIT]) && phy_control_reg[PHY_PDWN_BIT]
      |-> !phy_control_reg[PHY_CLKGD_BIT])
      else $error("clock good while down");
   a_clkgood_after_lock: assert property ($rose(phy_control_reg[PHY_CLKGD_BIT]) |-> $past(phy_pll_locked, 3))
      else $error("clock good without lock");
   a_line_polarity: assert property (up_cnt == 3'h7 && ($stable({line_rx_p, line_rx_n, phy_control_reg[PHY_POL_BIT]}))[*4]
      |-> {data_plus_pin, data_minus_pin} == (phy_control_reg[PHY_POL_BIT] ? {line_rx_n, line_rx_p}
                                                                         : {line_rx_p, line_rx_n}))
      else $error("lines miss polarity");
   a_role_from_pin: assert property (up_cnt == 3'h7 && ($stable(role_identify_pin))[*5]
      |-> host_role == !role_identify_pin)
      else $error("role misses identify pin");
   a_reset_event_pulse: assert property (reset_event |-> !host_role ##1 !reset_event)
      else $error("reset event in host or long");
   a_dma_start_cause: assert property (rx_dma_start |-> $past(reg_wr) && $past(reg_addr) >= OFS_BUFCNT_BASE
      && $past(reg_addr) < OFS_SESSION ##1 !rx_dma_start)
      else $error("dma start without count write");
endmodule
bind uofg_core uofg_properties #(.NUM_RX_CH(NUM_RX_CH), .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_props (
   .clk_sys, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .role_identify_pin, .phy_pll_locked,
   .line_rx_p, .line_rx_n, .vbus_supply_enable_out, .data_plus_pin, .data_minus_pin, .phy_control_reg,
   .host_role, .rx_dma_start, .reset_event);

//--- tb/uofg_cable_model.sv
`timescale 1ns/1ps
module uofg_cable_model (
   // Clock
   input  wire logic        clk_sys,
   // Bench controls
   input  wire logic        host_mode,
   input  wire logic        line_bit,
   input  wire logic        bus_rst,
   // From the device
   input  wire logic        vbus_supply_enable_out,
   input  wire logic [31:0] phy_control_reg,
   // To the device
   output wire logic        role_identify_pin,
   output wire logic        vbus_pin,
   output wire logic        phy_pll_locked,
   output wire logic        usb_bus_reset,
   output wire logic        line_rx_p,
   output wire logic        line_rx_n
);
   logic [3:0] lock_cnt = 4'h0;
   wire  logic pll_ready = phy_control_reg[7] & ~phy_control_reg[8] & ~phy_control_reg[10];
   // Host end grounds identify
   assign role_identify_pin = ~host_mode;
   // As host, VBUS follows our own supply
   assign vbus_pin = host_mode ? vbus_supply_enable_out : 1'h1;
   assign line_rx_p = line_bit;
   assign line_rx_n = ~line_bit;
   assign usb_bus_reset = bus_rst;
   // Lock drops at once on power-off
   always_ff @(posedge clk_sys) begin
      if (!pll_ready) lock_cnt <= 4'h0;
      else if (lock_cnt != 4'hf) lock_cnt <= lock_cnt + 4'h1;
   end
   assign phy_pll_locked = (lock_cnt == 4'hf);
endmodule

//--- tb/usb_otg_fifo_phy_vbus_control_tb.sv
`timescale 1ns/1ps
module usb_otg_fifo_phy_vbus_control_tb;
   import uofg_pkg::*;
   logic        clk_sys = 1'h0;
   logic        rstn = 1'h0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'h0;
   logic        reg_rd = 1'h0;
   logic        host_mode = 1'h0;
   logic        line_bit = 1'h0;
   logic        bus_rst = 1'h0;
   wire  logic  role_pin, vbus_pin, pll_lock, bus_line, rx_p, rx_n;
   wire  logic  supply_en, dp, dm, host_role, dma_start, rst_evt;
   wire  logic [31:0] reg_rdata, phy_ctrl;
   int          n_fail = 0;
   int          n_compared = 0;
   int          cyc = 0;
   always #2 clk_sys = ~clk_sys;
   //////////////////////////////////////////////////////////////////////
   // Short lock wait
   uofg_core #(.PLL_LOCK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .role_identify_pin(role_pin), .vbus_pin(vbus_pin), .phy_pll_locked(pll_lock),
      .usb_bus_reset(bus_line), .line_rx_p(rx_p), .line_rx_n(rx_n), .vbus_supply_enable_out(supply_en),
      .data_plus_pin(dp), .data_minus_pin(dm), .phy_control_reg(phy_ctrl), .host_role(host_role),
      .rx_dma_start(dma_start), .reset_event(rst_evt));
   uofg_cable_model cable_u (.clk_sys(clk_sys), .host_mode(host_mode), .line_bit(line_bit),
      .bus_rst(bus_rst), .vbus_supply_enable_out(supply_en), .phy_control_reg(phy_ctrl),
      .role_identify_pin(role_pin), .vbus_pin(vbus_pin), .phy_pll_locked(pll_lock),
      .usb_bus_reset(bus_line), .line_rx_p(rx_p), .line_rx_n(rx_n));
   //////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Data stand one cycle; sample just past it
   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 chk(nm, reg_rdata, exp);
   endtask
   task automatic wrap_up;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_phy;
      int i;
      rd_chk("unmapped", 12'h7f0, 32'h0);
      rd_chk("phy reset", 12'h600, PHY_CTRL_RESET);
      wr(12'h600, 32'h0000_00e2);
      rd_chk("phy early", 12'h600, 32'h0000_00e2);
      i = 0;
      while (phy_ctrl[PHY_CLKGD_BIT] !== 1'h1 && i < 100) begin
         @(posedge clk_sys);
         i++;
      end
      rd_chk("clk good", 12'h600, 32'h0000_08e2);
      line_bit <= 1'h1;
      repeat (6) @(posedge clk_sys);
      chk("lines normal", 32'({dp, dm}), 32'h2);
      wr(12'h600, 32'h0000_00f2);
      repeat (6) @(posedge clk_sys);
      chk("lines swapped", 32'({dp, dm}), 32'h1);
   endtask
   task automatic t_window;
      wr(12'h00e, 32'h2);
      wr(12'h41c, 32'h0040_0080);
      rd_chk("flat ep2", 12'h52c, 32'h0040_0080);
      wr(12'h534, 32'h0040_0013);
      wr(12'h00e, 32'h3);
      rd_chk("window ep3", 12'h414, 32'h0040_0013);
      wr(12'h00e, 32'h0);
      wr(12'h414, 32'h0040_0013);
      rd_chk("ep0 size", 12'h414, 32'h0);
      rd_chk("ep0 start", 12'h50c, 32'h0);
   endtask
   task automatic t_vbus;
      wr(12'h660, 32'h1);
      repeat (6) @(posedge clk_sys);
      chk("supply periph", 32'(supply_en), 32'h0);
      host_mode <= 1'h1;
      repeat (12) @(posedge clk_sys);
      chk("host role", 32'(host_role), 32'h1);
      chk("supply host", 32'(supply_en), 32'h1);
      rd_chk("status", 12'h604, 32'h7);
      wr(12'h660, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk("supply idle", 32'(supply_en), 32'h0);
      host_mode <= 1'h0;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic t_dma;
      wr(12'h608, 32'h1);
      wr(12'h620, 32'h0000_1000);
      wr(12'h00e, 32'h1);
      wr(12'h410, 32'h20);
      wr(12'h640, 32'h3);
      #1 chk("dma start", 32'(dma_start), 32'h1);
      rd_chk("buffer count", 12'h640, 32'h3);
      wr(12'h640, 32'h2);
      rd_chk("count summed", 12'h640, 32'h5);
   endtask
   task automatic t_busrst;
      logic got;
      got = 1'h0;
      wr(12'h00e, 32'h3);
      wr(12'h000, 32'h5);
      bus_rst <= 1'h1;
      repeat (10) begin
         @(posedge clk_sys);
         if (rst_evt === 1'h1) got = 1'h1;
      end
      chk("reset event", 32'(got), 32'h1);
      bus_rst <= 1'h0;
      rd_chk("index cleared", 12'h00e, 32'h0);
      rd_chk("address cleared", 12'h000, 32'h0);
      rd_chk("status cleared", 12'h510, 32'h0);
   endtask
   //////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      chk("phy pin reset", phy_ctrl, PHY_CTRL_RESET);
      rstn <= 1'h1;
      t_phy();
      t_window();
      t_vbus();
      t_dma();
      t_busrst();
      wrap_up();
   end
endmodule
